// file: logic/flash_unlock_and_address_regs.sv
// APB register block with unlock key, flash target address and operation launch
`timescale 1ns/1ps
`default_nettype none
// Function
// - Key register write-only, reads zero, resets zero
// - Key writes form the unlock sequence guarding flash
// - Target address register readable, writable, resets zero
// - Chip erase ignores the target address
// - Page erase uses address to pick page
// - Row program uses address to pick row
// - Word program uses address to pick word
module flash_unlock_and_address_regs #(
    parameter logic [31:0] FIRST_KEY  = flash_unlock_pkg::FIRST_KEY_DEFAULT,
    parameter logic [31:0] SECOND_KEY = flash_unlock_pkg::SECOND_KEY_DEFAULT,
    parameter int unsigned WORD_BYTES = flash_unlock_pkg::WORD_BYTES_DEFAULT,
    parameter int unsigned ROW_BYTES  = flash_unlock_pkg::ROW_BYTES_DEFAULT,
    parameter int unsigned PAGE_BYTES = flash_unlock_pkg::PAGE_BYTES_DEFAULT
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        op_done,
    output logic             op_start,
    output logic      [2:0]  op_kind,
    output logic      [31:0] op_addr
);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter checks
    function automatic logic is_pow2(input int unsigned v);
        is_pow2 = (v != 0) && ((v & (v - 1)) == 0);
    endfunction : is_pow2

    if (!is_pow2(WORD_BYTES) || !is_pow2(ROW_BYTES) || !is_pow2(PAGE_BYTES) ||
        WORD_BYTES > ROW_BYTES || ROW_BYTES > PAGE_BYTES) begin : g_bad_geometry
        $error("Flash geometry must be powers of two with word <= row <= page");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] align_down(input logic [31:0] a, input int unsigned bytes);
        logic [31:0] mask;
        mask = 32'(bytes - 1);
        align_down = a & ~mask;
    endfunction : align_down

    function automatic logic [31:0] target_of(input logic [2:0] kind, input logic [31:0] a);
        case (kind)
            flash_unlock_pkg::OP_WORD: target_of = align_down(a, WORD_BYTES);
            flash_unlock_pkg::OP_ROW:  target_of = align_down(a, ROW_BYTES);
            flash_unlock_pkg::OP_PAGE: target_of = align_down(a, PAGE_BYTES);
            default:                   target_of = 32'h00000000;
        endcase
    endfunction : target_of

    function automatic logic kind_valid(input logic [2:0] kind);
        kind_valid = (kind == flash_unlock_pkg::OP_WORD) || (kind == flash_unlock_pkg::OP_ROW) ||
                     (kind == flash_unlock_pkg::OP_PAGE) || (kind == flash_unlock_pkg::OP_CHIP);
    endfunction : kind_valid

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        merge_bytes = r;
    endfunction : merge_bytes

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [31:0] addr_q;
    logic [31:0] addr_d;
    logic [2:0]  op_sel_q;
    logic [2:0]  op_sel_d;
    logic        busy_q;
    logic        busy_d;
    logic        done_q;
    logic        done_d;
    logic        err_q;
    logic        err_d;
    logic        op_start_q;
    logic        op_start_d;
    logic [2:0]  op_kind_q;
    logic [2:0]  op_kind_d;
    logic [31:0] op_addr_q;
    logic [31:0] op_addr_d;

    logic        sel_key;
    logic        sel_addr;
    logic        sel_ctrl;
    logic        mapped;
    logic        commit;
    logic        key_write;
    logic        consume;
    logic        unlocked;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////////
    // Unlock sequence
    unlock_sequencer #(
        .FIRST_KEY  (FIRST_KEY),
        .SECOND_KEY (SECOND_KEY)
    ) u_unlock (
        .mclk      (mclk),
        .rst       (rst),
        .ce        (ce),
        .key_write (key_write),
        .key_whole (&pstrb),
        .key_value (pwdata),
        .consume   (consume),
        .unlocked  (unlocked)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    assign sel_key   = (paddr == flash_unlock_pkg::KEY_OFFSET);
    assign sel_addr  = (paddr == flash_unlock_pkg::ADDR_OFFSET);
    assign sel_ctrl  = (paddr == flash_unlock_pkg::CTRL_OFFSET);
    assign mapped    = sel_key | sel_addr | sel_ctrl;
    assign commit    = psel & penable & pready_q;
    assign key_write = commit & pwrite & sel_key;

    always_comb begin
        status_word = flash_unlock_pkg::READ_ZERO;
        status_word[flash_unlock_pkg::CTRL_OP_LSB +: flash_unlock_pkg::CTRL_OP_W] = op_sel_q;
        status_word[flash_unlock_pkg::STAT_UNLOCKED] = unlocked;
        status_word[flash_unlock_pkg::STAT_BUSY]     = busy_q;
        status_word[flash_unlock_pkg::STAT_DONE]     = done_q;
        status_word[flash_unlock_pkg::STAT_ERR]      = err_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next values
    always_comb begin
        pready_d   = psel & penable & ~pready_q;
        pslverr_d  = psel & penable & ~pready_q & ~mapped;
        prdata_d   = flash_unlock_pkg::READ_ZERO;
        addr_d     = addr_q;
        op_sel_d   = op_sel_q;
        busy_d     = busy_q;
        done_d     = done_q;
        err_d      = err_q;
        op_start_d = 1'b0;
        op_kind_d  = op_kind_q;
        op_addr_d  = op_addr_q;
        consume    = 1'b0;

        if (pready_d && !pwrite) begin
            if (sel_addr) begin
                prdata_d = addr_q;
            end else if (sel_ctrl) begin
                prdata_d = status_word;
            end else begin
                prdata_d = flash_unlock_pkg::READ_ZERO;
            end
        end

        if (commit && pwrite && sel_addr) begin
            addr_d = merge_bytes(addr_q, pwdata, pstrb);
        end

        if (commit && pwrite && sel_ctrl) begin
            if (pstrb[0]) begin
                op_sel_d = pwdata[flash_unlock_pkg::CTRL_OP_LSB +: flash_unlock_pkg::CTRL_OP_W];
            end
            if (pstrb[2] && pwdata[flash_unlock_pkg::STAT_DONE]) begin
                done_d = 1'b0;
            end
            if (pstrb[2] && pwdata[flash_unlock_pkg::STAT_ERR]) begin
                err_d = 1'b0;
            end
            if (pstrb[1] && pwdata[flash_unlock_pkg::CTRL_START]) begin
                if (unlocked && !busy_q && kind_valid(op_sel_d)) begin
                    op_start_d = 1'b1;
                    busy_d     = 1'b1;
                    consume    = 1'b1;
                    op_kind_d  = op_sel_d;
                    op_addr_d  = target_of(op_sel_d, addr_q);
                end else begin
                    err_d = 1'b1;
                end
            end
        end

        if (op_done && busy_q) begin
            busy_d = 1'b0;
            done_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            prdata_q   <= flash_unlock_pkg::READ_ZERO;
            addr_q     <= flash_unlock_pkg::ADDR_RESET;
            op_sel_q   <= flash_unlock_pkg::OP_NONE;
            busy_q     <= 1'b0;
            done_q     <= 1'b0;
            err_q      <= 1'b0;
            op_start_q <= 1'b0;
            op_kind_q  <= flash_unlock_pkg::OP_NONE;
            op_addr_q  <= flash_unlock_pkg::ADDR_RESET;
        end else if (ce) begin
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
            prdata_q   <= prdata_d;
            addr_q     <= addr_d;
            op_sel_q   <= op_sel_d;
            busy_q     <= busy_d;
            done_q     <= done_d;
            err_q      <= err_d;
            op_start_q <= op_start_d;
            op_kind_q  <= op_kind_d;
            op_addr_q  <= op_addr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign op_start = op_start_q;
    assign op_kind  = op_kind_q;
    assign op_addr  = op_addr_q;

endmodule : flash_unlock_and_address_regs
`default_nettype wire

// file: logic/flash_unlock_pkg.sv
// Constants shared by the flash unlock and target address register block
package flash_unlock_pkg;

    localparam int unsigned DATA_W     = 32;
    localparam int unsigned APB_ADDR_W = 8;
    localparam int unsigned STRB_W     = 4;

    // Register byte offsets
    localparam logic [7:0] KEY_OFFSET  = 8'h00;
    localparam logic [7:0] ADDR_OFFSET = 8'h04;
    localparam logic [7:0] CTRL_OFFSET = 8'h08;

    // Values after reset
    localparam logic [31:0] KEY_RESET  = 32'h00000000;
    localparam logic [31:0] ADDR_RESET = 32'h00000000;
    localparam logic [31:0] READ_ZERO  = 32'h00000000;

    // Control and status field positions
    localparam int unsigned CTRL_OP_LSB   = 0;
    localparam int unsigned CTRL_OP_W     = 3;
    localparam int unsigned CTRL_START    = 15;
    localparam int unsigned STAT_UNLOCKED = 16;
    localparam int unsigned STAT_BUSY     = 17;
    localparam int unsigned STAT_DONE     = 18;
    localparam int unsigned STAT_ERR      = 19;

    // Default unlock keys, values arbitrary
    localparam logic [31:0] FIRST_KEY_DEFAULT  = 32'h5A5A0F0F;
    localparam logic [31:0] SECOND_KEY_DEFAULT = 32'hA5A5F0F0;

    // Default flash geometry in bytes
    localparam int unsigned WORD_BYTES_DEFAULT = 4;
    localparam int unsigned ROW_BYTES_DEFAULT  = 128;
    localparam int unsigned PAGE_BYTES_DEFAULT = 1024;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_WORD = 3'h1,
        OP_ROW  = 3'h2,
        OP_PAGE = 3'h3,
        OP_CHIP = 3'h4
    } op_kind_t;

    typedef enum logic [2:0] {
        SEQ_LOCKED = 3'b001,
        SEQ_HALF   = 3'b010,
        SEQ_OPEN   = 3'b100
    } seq_state_t;

endpackage : flash_unlock_pkg

// file: logic/unlock_sequencer.sv
// Two-key unlock sequence that gates flash modification
`timescale 1ns/1ps
`default_nettype none
module unlock_sequencer #(
    parameter logic [31:0] FIRST_KEY  = flash_unlock_pkg::FIRST_KEY_DEFAULT,
    parameter logic [31:0] SECOND_KEY = flash_unlock_pkg::SECOND_KEY_DEFAULT
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        key_write,
    input  wire logic        key_whole,
    input  wire logic [31:0] key_value,
    input  wire logic        consume,
    output logic             unlocked
);

    flash_unlock_pkg::seq_state_t state_q;
    flash_unlock_pkg::seq_state_t state_d;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_d = state_q;
        if (consume) begin
            state_d = flash_unlock_pkg::SEQ_LOCKED;
        end else if (key_write) begin
            case (state_q)
                flash_unlock_pkg::SEQ_HALF: begin
                    state_d = (key_whole && key_value == SECOND_KEY) ?
                              flash_unlock_pkg::SEQ_OPEN : flash_unlock_pkg::SEQ_LOCKED;
                end
                default: begin
                    state_d = (key_whole && key_value == FIRST_KEY) ?
                              flash_unlock_pkg::SEQ_HALF : flash_unlock_pkg::SEQ_LOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= flash_unlock_pkg::SEQ_LOCKED;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    assign unlocked = (state_q == flash_unlock_pkg::SEQ_OPEN);

endmodule : unlock_sequencer
`default_nettype wire

// file: verification/flash_unlock_chk.sv
// Port assertions for the unlock key and target address block
`timescale 1ns/1ps
`default_nettype none
module flash_unlock_chk #(
    parameter int unsigned WORD_BYTES = 4,
    parameter int unsigned ROW_BYTES  = 128,
    parameter int unsigned PAGE_BYTES = 1024
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        op_done,
    input wire logic        op_start,
    input wire logic [2:0]  op_kind,
    input wire logic [31:0] op_addr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    AST_KEY_READ_ZERO: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata == 32'h0)
        else $error("key read not zero");
    AST_ANSWER: assert property (ce && psel && penable && !pready |=> pready)
        else $error("no answer after access edge");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_DECODE: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
        else $error("slave error decode wrong");
    AST_START_CAUSE: assert property (op_start |->
        $past(psel && penable && pready && pwrite && paddr == 8'h08 && pwdata[15] && pstrb[1]))
        else $error("launch without start write");
    AST_START_PULSE: assert property (op_start |=> !op_start)
        else $error("launch longer than one cycle");
    AST_CHIP: assert property (op_start && op_kind == 3'h4 |-> op_addr == 32'h0)
        else $error("chip erase address not ignored");
    AST_PAGE: assert property (op_start && op_kind == 3'h3 |-> (op_addr & (PAGE_BYTES - 1)) == 0)
        else $error("page address not aligned");
    AST_ROW: assert property (op_start && op_kind == 3'h2 |-> (op_addr & (ROW_BYTES - 1)) == 0)
        else $error("row address not aligned");
    AST_WORD: assert property (op_start && op_kind == 3'h1 |-> (op_addr & (WORD_BYTES - 1)) == 0)
        else $error("word address not aligned");
    AST_HOLD: assert property (!op_start |-> $stable(op_addr) && $stable(op_kind))
        else $error("launch outputs moved without launch");
endmodule : flash_unlock_chk
`default_nettype wire

// file: verification/test_flash_unlock_and_address_regs.sv
// Self-checking bench for the unlock key and target address block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module test_flash_unlock_and_address_regs;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
    logic        mclk, rst, ce, psel, penable, pwrite, op_done, pready, pslverr, op_start, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, op_addr, rdat, exp_a;
    logic [3:0]  pstrb;
    logic [2:0]  op_kind;
    int          num_errors = 0, checks = 0, starts = 0, n0;
    int unsigned bsz [4] = '{4, 128, 1024, 0};
    row_t rows [9] = '{'{1, 8'h04, 32'h12345678, 0, 0}, '{0, 8'h04, 0, 32'h12345678, 0},
        '{1, 8'h00, 32'hFFFFFFFF, 0, 0}, '{0, 8'h00, 0, 0, 0}, '{1, 8'h04, 32'hFFFFFFFF, 0, 0},
        '{0, 8'h04, 0, 32'hFFFFFFFF, 0}, '{0, 8'h0C, 0, 0, 1}, '{1, 8'h40, 32'h1, 0, 1},
        '{0, 8'h04, 0, 32'hFFFFFFFF, 0}};
    flash_unlock_and_address_regs u_flash_unlock_and_address_regs (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op_done(op_done), .op_start(op_start), .op_kind(op_kind),
        .op_addr(op_addr));
    ////////////////////////////////////////////////////////////////
    task automatic results();
        if (num_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin @(posedge mclk); end while (pready !== 1'b1);
        rdat = prdata; rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    ////////////////////////////////////////////////////////////////
    initial begin mclk = 1'b0; forever #20 mclk = ~mclk; end
    initial begin repeat (5000) @(posedge mclk); num_errors++; results(); end
    always @(posedge mclk) if (op_start === 1'b1) starts++;
    initial begin
        rst <= 1'b1; ce <= 1'b1; psel <= 1'b0; penable <= 1'b0; pwrite <= 1'b0; paddr <= 8'h00;
        pwdata <= 32'h0; pstrb <= 4'hF; op_done <= 1'b0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        apb(0, 8'h00, 0); `CHK("key reset", 32'h0, rdat)
        apb(0, 8'h04, 0); `CHK("addr reset", 32'h0, rdat)
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            `CHK("row data", rows[i].x, rdat)
            `CHK("row err", rows[i].e, rerr)
        end
        for (int k = 4; k >= 1; k--) begin
            apb(1, 8'h04, 32'h00001FFF);
            apb(1, 8'h00, 32'h5A5A0F0F); apb(1, 8'h00, 32'hA5A5F0F0);
            n0 = starts;
            apb(1, 8'h08, 32'h00008000 | k);
            @(posedge mclk);
            exp_a = (k == 4) ? 32'h0 : 32'h00001FFF & ~(bsz[k-1] - 1);
            `CHK("launch", n0 + 1, starts)
            `CHK("kind", 3'(k), op_kind)
            `CHK("target", exp_a, op_addr)
            ce <= 1'b0; op_done <= 1'b1; @(posedge mclk);
            ce <= 1'b1; op_done <= 1'b0; @(posedge mclk);
            apb(0, 8'h08, 0); `CHK("relock busy", 2'b10, rdat[17:16])
            op_done <= 1'b1; @(posedge mclk); op_done <= 1'b0; @(posedge mclk);
            apb(0, 8'h08, 0); `CHK("done idle", 2'b10, rdat[18:17])
            apb(1, 8'h08, 32'h00040000);
            apb(0, 8'h08, 0); `CHK("done clear", 32'h0, rdat)
        end
        n0 = starts;
        apb(1, 8'h00, 32'h5A5A0F0F); apb(1, 8'h00, 32'h12345678); apb(1, 8'h00, 32'hA5A5F0F0);
        apb(1, 8'h08, 32'h00008001);
        @(posedge mclk);
        `CHK("locked launch", n0, starts)
        apb(0, 8'h08, 0); `CHK("err unlocked", 2'b10, {rdat[19], rdat[16]})
        apb(1, 8'h04, 32'h000000A5);
        apb(1, 8'h00, 32'h5A5A0F0F); apb(1, 8'h00, 32'hA5A5F0F0);
        rst <= 1'b1; @(posedge mclk); @(posedge mclk); rst <= 1'b0; @(posedge mclk);
        apb(0, 8'h04, 0); `CHK("addr second reset", 32'h0, rdat)
        `CHK("target reset", 32'h0, op_addr)
        `CHK("kind reset", 3'h0, op_kind)
        apb(0, 8'h08, 0); `CHK("ctrl reset", 32'h0, rdat)
        pstrb <= 4'h1;
        apb(1, 8'h04, 32'hFFFFFF5A);
        pstrb <= 4'hF;
        apb(0, 8'h04, 0); `CHK("addr byte lane", 32'h0000005A, rdat)
        results();
    end
endmodule : test_flash_unlock_and_address_regs
bind flash_unlock_and_address_regs flash_unlock_chk #(.WORD_BYTES(WORD_BYTES), .ROW_BYTES(ROW_BYTES),
    .PAGE_BYTES(PAGE_BYTES)) u_flash_unlock_chk (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_done(op_done), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr));
`default_nettype wire
